// File: rtl/hpt_pkg.sv
// Package for the host power timing and wake block: register map, reset values, timing.
// Assumes a 10 MHz system clock and a byte-wide register port decoded by an I2C front end.
package hpt_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_OFF_DELAY_LO = 8'h1c;
    localparam logic [7:0] ADDR_OFF_DELAY_HI = 8'h1d;
    localparam logic [7:0] ADDR_LOSS_MIN_LO = 8'h1e;
    localparam logic [7:0] ADDR_LOSS_MIN_HI = 8'h1f;
    localparam logic [7:0] ADDR_BOOT_TO = 8'h21;
    localparam logic [7:0] ADDR_SHDN_TO = 8'h22;
    localparam logic [7:0] ADDR_SECONDS = 8'h28;
    localparam logic [7:0] ADDR_WAKE = 8'h2c;
    // Reset values.
    localparam logic [15:0] RST_OFF_DELAY = 16'h0028;
    localparam logic [15:0] RST_LOSS_MIN = 16'hffff;
    localparam logic [7:0] RST_BOOT_TO = 8'h1e;
    localparam logic [7:0] RST_SHDN_TO = 8'h0c;
    localparam logic [31:0] RST_WAKE = 32'h0000_0000;
    localparam logic [15:0] LOSS_DISABLED = 16'hffff;
    // Time units.
    localparam int TICKS_PER_SEC = 8;
    localparam int SECS_PER_TIMEOUT_UNIT = 10;
    localparam int SECS_PER_MINUTE = 60;
    localparam int SEC_WIDTH = 32;
    // Host power state machine, one-hot.
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_BOOT = 4'h2,
        ST_RUN = 4'h4,
        ST_SHDN = 4'h8
    } hpt_state_e;
endpackage

// File: rtl/hpt_power_timing.sv
// Host power sequencing timers, seconds counter and absolute wake comparator.
// Assumes an I2C slave front end presents byte reads and writes, and that the
// 8 Hz tick and 1 Hz second strobe are one-cycle pulses derived elsewhere from
// the watch-crystal time base, synchronous to mclk.
module hpt_power_timing
    import hpt_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic tick_8hz, // One-cycle system tick pulse.
    input wire logic sec_pulse, // One-cycle pulse each crystal second.
    input wire logic host_tx, // Host UART transmit line level.
    input wire logic iout_below_thresh, // Output current under shutdown threshold.
    input wire logic vin_below_thresh, // Input voltage under threshold.
    input wire logic vbat_below_shdn, // Battery under shutdown threshold.
    input wire logic boot_request, // Boot request from other sources.
    input wire logic host_booted, // Host reports it is running.
    input wire logic reg_wr, // Register byte write strobe.
    input wire logic reg_rd, // Register byte read strobe.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic host_power_en,
    output logic shutdown_request,
    output logic wake_pending,
    output logic [3:0] power_state
);
    // All block state in one record.
    typedef struct packed {
        hpt_state_e st;
        logic [15:0] dly;
        logic [15:0] loss_min;
        logic [7:0] boot_to;
        logic [7:0] shdn_to;
        logic [31:0] secs;
        logic [31:0] wake;
        logic [15:0] dly_cnt; // Ticks since shutdown detected.
        logic detected; // Host shutdown seen in shutdown state.
        logic [15:0] to_secs; // Seconds in boot or shutdown state.
        logic [5:0] min_secs; // Seconds within current loss minute.
        logic [15:0] loss_cnt; // Whole minutes on lost input.
        logic shdn_req;
        logic [7:0] rdata;
    } hpt_s;

    hpt_s q_r;
    hpt_s q_nxt;

    // Address match helper, used by both the read and write decoders.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        return a == base;
    endfunction

    // Pick one byte of a word by the low address bits.
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
        return w[{i, 3'b000} +: 8];
    endfunction

    // Four-byte word match on the upper address bits, used by both decoders.
    function automatic logic in_word(input logic [7:0] a, input logic [7:0] base);
        return a[7:2] == base[7:2];
    endfunction

    // Decoded conditions shared by the state machine, the outputs and the checks.
    logic wake_hit; // Pending wake time has been reached.
    logic host_down; // Host looks shut down by either detection method.
    logic boot_expired; // Boot timeout has run out.
    logic shdn_expired; // Shutdown timeout has run out.
    logic [15:0] boot_lim; // Boot timeout in seconds.
    logic [15:0] shdn_lim; // Shutdown timeout in seconds.

    // Limits in seconds; the register only holds ten-second units.
    assign boot_lim = 16'(q_r.boot_to) * 16'(SECS_PER_TIMEOUT_UNIT);
    assign shdn_lim = 16'(q_r.shdn_to) * 16'(SECS_PER_TIMEOUT_UNIT);
    // Greater-or-equal so a missed exact second still wakes; zero means idle.
    assign wake_hit = (q_r.wake != RST_WAKE) && (q_r.secs >= q_r.wake);
    assign host_down = !host_tx || iout_below_thresh;
    assign boot_expired = (q_r.boot_to != 8'h00) && (q_r.to_secs >= boot_lim);
    assign shdn_expired = (q_r.shdn_to != 8'h00) && (q_r.to_secs >= shdn_lim);

    // Next-state logic for the whole block.
    always_comb begin
        q_nxt = q_r;
        q_nxt.shdn_req = 1'b0;
        // Seconds counter keeps running regardless of host power.
        if (sec_pulse) begin
            q_nxt.secs = q_r.secs + 32'h0000_0001;
        end
        // Timeout seconds count only in boot and shutdown states.
        if (q_r.st == ST_BOOT || q_r.st == ST_SHDN) begin
            if (sec_pulse && q_r.to_secs != 16'hffff) begin
                q_nxt.to_secs = q_r.to_secs + 16'h0001;
            end
        end else begin
            q_nxt.to_secs = 16'h0000;
        end
        // Input-loss minute counter; only meaningful while running.
        if (q_r.st == ST_RUN && vin_below_thresh) begin
            if (sec_pulse) begin
                if (q_r.min_secs == 6'(SECS_PER_MINUTE - 1)) begin
                    q_nxt.min_secs = 6'h00;
                    if (q_r.loss_cnt != 16'hffff) begin
                        q_nxt.loss_cnt = q_r.loss_cnt + 16'h0001;
                    end
                end else begin
                    q_nxt.min_secs = q_r.min_secs + 6'h01;
                end
            end
        end else begin
            q_nxt.min_secs = 6'h00;
            q_nxt.loss_cnt = 16'h0000;
        end
        // Power state machine.
        case (q_r.st)
            ST_OFF: begin
                // Host unpowered: forget any detection from the last shutdown.
                q_nxt.detected = 1'b0;
                q_nxt.dly_cnt = 16'h0000;
                // A missed wake time still boots the host as soon as it is off.
                if (wake_hit) begin
                    q_nxt.st = ST_BOOT;
                    q_nxt.wake = RST_WAKE;
                end else if (boot_request) begin
                    q_nxt.st = ST_BOOT;
                end
            end
            ST_BOOT: begin
                // Wait for the host to report in; give up when the timeout runs out.
                if (host_booted) begin
                    q_nxt.st = ST_RUN;
                end else if (boot_expired) begin
                    q_nxt.st = ST_OFF;
                end
            end
            ST_RUN: begin
                // Battery check wins over any remaining minutes.
                if (vbat_below_shdn) begin
                    q_nxt.st = ST_SHDN;
                    q_nxt.shdn_req = 1'b1;
                end else if (vin_below_thresh && q_r.loss_min != LOSS_DISABLED
                        && q_r.loss_cnt >= q_r.loss_min) begin
                    q_nxt.st = ST_SHDN;
                    q_nxt.shdn_req = 1'b1;
                end
            end
            ST_SHDN: begin
                // Detection latches, so a glitch back high does not restart the delay.
                if (host_down) begin
                    q_nxt.detected = 1'b1;
                end
                if (q_r.detected && tick_8hz) begin
                    q_nxt.dly_cnt = q_r.dly_cnt + 16'h0001;
                end
                // The shutdown timeout only applies while the host still looks alive.
                if (q_r.detected && q_r.dly_cnt >= q_r.dly) begin
                    q_nxt.st = ST_OFF;
                end else if (!q_r.detected && shdn_expired) begin
                    q_nxt.st = ST_OFF;
                end
            end
            default: begin
                // An illegal code falls back to the safe, unpowered state.
                q_nxt.st = ST_OFF;
            end
        endcase
        // Host register writes; a write in the boot cycle overrides the wake clear.
        if (reg_wr) begin
            // The two halves of a 16-bit register are written one byte at a time.
            if (hit(reg_addr, ADDR_OFF_DELAY_LO)) q_nxt.dly[7:0] = reg_wdata;
            if (hit(reg_addr, ADDR_OFF_DELAY_HI)) q_nxt.dly[15:8] = reg_wdata;
            if (hit(reg_addr, ADDR_LOSS_MIN_LO)) q_nxt.loss_min[7:0] = reg_wdata;
            if (hit(reg_addr, ADDR_LOSS_MIN_HI)) q_nxt.loss_min[15:8] = reg_wdata;
            if (hit(reg_addr, ADDR_BOOT_TO)) q_nxt.boot_to = reg_wdata;
            if (hit(reg_addr, ADDR_SHDN_TO)) q_nxt.shdn_to = reg_wdata;
            // No shadow latch: the counter may carry between two byte writes.
            if (in_word(reg_addr, ADDR_SECONDS)) begin
                q_nxt.secs[{reg_addr[1:0], 3'b000} +: 8] = reg_wdata;
            end
            if (in_word(reg_addr, ADDR_WAKE)) begin
                q_nxt.wake[{reg_addr[1:0], 3'b000} +: 8] = reg_wdata;
            end
        end
        // Read data is registered; unmapped addresses read zero.
        if (reg_rd) begin
            q_nxt.rdata = 8'h00;
            if (hit(reg_addr, ADDR_OFF_DELAY_LO)) q_nxt.rdata = q_r.dly[7:0];
            if (hit(reg_addr, ADDR_OFF_DELAY_HI)) q_nxt.rdata = q_r.dly[15:8];
            if (hit(reg_addr, ADDR_LOSS_MIN_LO)) q_nxt.rdata = q_r.loss_min[7:0];
            if (hit(reg_addr, ADDR_LOSS_MIN_HI)) q_nxt.rdata = q_r.loss_min[15:8];
            if (hit(reg_addr, ADDR_BOOT_TO)) q_nxt.rdata = q_r.boot_to;
            if (hit(reg_addr, ADDR_SHDN_TO)) q_nxt.rdata = q_r.shdn_to;
            // Words are read a byte at a time, so a carry between reads is possible.
            if (in_word(reg_addr, ADDR_SECONDS)) q_nxt.rdata = byte_of(q_r.secs, reg_addr[1:0]);
            if (in_word(reg_addr, ADDR_WAKE)) q_nxt.rdata = byte_of(q_r.wake, reg_addr[1:0]);
        end
    end

    // State register; the seconds counter starts at zero after reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Clearing the whole record first starts the seconds counter at zero.
            q_r <= '0;
            q_r.st <= ST_OFF;
            q_r.dly <= RST_OFF_DELAY;
            q_r.loss_min <= RST_LOSS_MIN;
            q_r.boot_to <= RST_BOOT_TO;
            q_r.shdn_to <= RST_SHDN_TO;
            q_r.wake <= RST_WAKE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs; power enable and wake pending are plain decodes of registered state.
    assign reg_rdata = q_r.rdata;
    assign host_power_en = (q_r.st != ST_OFF);
    assign shutdown_request = q_r.shdn_req;
    assign wake_pending = wake_hit;
    assign power_state = q_r.st;

    // Checks. Each one reads the registered state, so it sees settled values.
    // A wake found while off must boot the host at the next edge.
    a_wake_boot: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_OFF && wake_hit) |=> (q_r.st == ST_BOOT))
        else $error("wake did not boot");
    // The wake that boots is cleared, unless the host rewrites the wake word then.
    a_wake_clear: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_OFF && wake_hit && !(reg_wr && in_word(reg_addr, ADDR_WAKE)))
        |=> (q_r.wake == RST_WAKE))
        else $error("wake time not cleared");
    // A zero wake time must never boot the host on its own.
    a_wake_zero: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_OFF && q_r.wake == RST_WAKE && !boot_request) |=> !host_power_en)
        else $error("zero wake time fired");
    // Low battery leaves the run state at once and pulses the request.
    a_vbat_first: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_RUN && vbat_below_shdn) |=> (q_r.st == ST_SHDN && shutdown_request))
        else $error("battery shutdown late");
    // All-ones minutes keep the host running on input loss.
    a_loss_off: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_RUN && !vbat_below_shdn && q_r.loss_min == LOSS_DISABLED)
        |=> (q_r.st == ST_RUN))
        else $error("disabled auto shutdown fired");
    // Zero minutes shut down at the first edge with input lost.
    a_loss_now: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_RUN && vin_below_thresh && q_r.loss_min == 16'h0000)
        |=> (q_r.st == ST_SHDN))
        else $error("zero minute shutdown late");
    // Input loss waits until the whole programmed minutes have been counted.
    a_loss_wait: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_RUN && !vbat_below_shdn && q_r.loss_cnt < q_r.loss_min)
        |=> (q_r.st == ST_RUN))
        else $error("input loss shutdown early");
    // Power stays on until the delay count has been reached.
    a_delay_off: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_SHDN && q_r.detected && q_r.dly_cnt < q_r.dly) |=> host_power_en)
        else $error("power cut before delay");
    // Either detection method latches detection in the shutdown state.
    a_detect_set: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_SHDN && host_down) |=> q_r.detected)
        else $error("host shutdown not detected");
    // A zero boot timeout keeps waiting for the host.
    a_boot_hold: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_BOOT && q_r.boot_to == 8'h00 && !host_booted) |=> (q_r.st == ST_BOOT))
        else $error("disabled boot timeout fired");
    // An expired boot timeout cuts power at the next edge.
    a_boot_cut: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_BOOT && !host_booted && boot_expired) |=> !host_power_en)
        else $error("boot timeout ignored");
    // A zero shutdown timeout leaves power-off to the detection methods.
    a_shdn_hold: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_SHDN && q_r.shdn_to == 8'h00 && !q_r.detected) |=> (q_r.st == ST_SHDN))
        else $error("disabled shutdown timeout fired");
    // An expired shutdown timeout cuts power while the host still looks alive.
    a_shdn_cut: assert property (@(posedge mclk) disable iff (srst)
        (q_r.st == ST_SHDN && !q_r.detected && shdn_expired) |=> !host_power_en)
        else $error("shutdown timeout ignored");
    // The seconds counter steps on every crystal second unless the host loads it.
    a_sec_count: assert property (@(posedge mclk) disable iff (srst)
        (sec_pulse && !(reg_wr && in_word(reg_addr, ADDR_SECONDS)))
        |=> (q_r.secs == $past(q_r.secs) + 32'h0000_0001))
        else $error("seconds did not count");
    // Main scenarios that the bench is expected to reach.
    c_wake: cover property (@(posedge mclk) q_r.st == ST_OFF && wake_hit);
    c_loss: cover property (@(posedge mclk) q_r.st == ST_RUN && q_r.loss_cnt != 16'h0000);
    c_boot_to: cover property (@(posedge mclk) q_r.st == ST_BOOT && boot_expired);
    c_shdn_to: cover property (@(posedge mclk) q_r.st == ST_SHDN && shdn_expired);
    c_delay: cover property (@(posedge mclk) q_r.detected && q_r.dly_cnt >= q_r.dly);
endmodule

// File: test/hpt_host_model.sv
// Host board model for the power sequencer bench.
// Assumes it sees the sequencer's power enable and one-hot state on mclk.
module hpt_host_model
    import hpt_pkg::*;
(
    input wire logic mclk,
    input wire logic power_en,
    input wire logic [3:0] state,
    input wire logic answer, // High: the host reports itself booted once powered.
    input wire logic clean, // High: the host drops its transmit line when shut down.
    output logic tx = 1'b0,
    output logic booted = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // An unpowered host cannot hold its transmit line up, so it reads low.
    // A host that never answers keeps booted low, which lets the boot timeout run.
    always @(posedge mclk) begin
        booted <= power_en && answer && state != ST_SHDN;
        tx <= power_en && !(clean && state == ST_SHDN);
    end
endmodule

// File: test/host_power_timing_rtc_tb.sv
// Self-checking bench for the host power timing and wake block.
// Assumes byte register strobes and bench-made tick and second pulses.
module host_power_timing_rtc_tb import hpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, srst = 1'b1, tick = 1'b0, sec = 1'b0, vin = 1'b0, vbat = 1'b0;
    logic iout = 1'b0, boot_req = 1'b0, answer = 1'b0, clean = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic tx, booted, pwr, sreq, wpend;
    logic [3:0] state;
    int errors = 0, n_checks = 0, n_req = 0, cycles = 0;
    // Reset contents of the six 16-bit and 8-bit register bytes and the lowest byte of each 32-bit word, low byte at the lower address.
    logic [7:0] ra[8] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h22, 8'h2c, 8'h28};
    logic [7:0] rv[8] = '{8'h28, 8'h00, 8'hff, 8'hff, 8'h1e, 8'h0c, 8'h00, 8'h00};
    always #50 mclk = ~mclk;
    hpt_power_timing i_hpt_power_timing (.mclk(mclk), .srst(srst), .tick_8hz(tick),
        .sec_pulse(sec), .host_tx(tx), .iout_below_thresh(iout), .vin_below_thresh(vin),
        .vbat_below_shdn(vbat), .boot_request(boot_req), .host_booted(booted),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .host_power_en(pwr), .shutdown_request(sreq), .wake_pending(wpend),
        .power_state(state));
    hpt_host_model i_hpt_host_model (.mclk(mclk), .power_en(pwr), .state(state),
        .answer(answer), .clean(clean), .tx(tx), .booted(booted));
    // Inputs change one nanosecond after the rising edge, clear of sampling.
    task automatic cyc(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each access starts one edge late so a strobe is never lowered and raised at once.
    task automatic wr8(logic [7:0] a, logic [7:0] d);
        cyc();
        wr = 1'b1;
        addr = a;
        wdata = d;
        cyc();
        wr = 1'b0;
    endtask
    task automatic rd8(logic [7:0] a, logic [7:0] exp);
        cyc();
        rd = 1'b1;
        addr = a;
        cyc();
        rd = 1'b0;
        chk("read data", {24'h0, exp}, {24'h0, rdata});
    endtask
    task automatic wr32(logic [7:0] a, logic [31:0] v);
        for (int i = 0; i < 4; i++) wr8(a + 8'(i), v[8*i+:8]);
    endtask
    task automatic rd32(logic [7:0] a, logic [31:0] v);
        for (int i = 0; i < 4; i++) rd8(a + 8'(i), v[8*i+:8]);
    endtask
    task automatic secs(int n);
        repeat (n) begin
            cyc();
            sec = 1'b1;
            cyc();
            sec = 1'b0;
        end
    endtask
    task automatic ticks(int n);
        repeat (n) begin
            cyc();
            tick = 1'b1;
            cyc();
            tick = 1'b0;
        end
    endtask
    // Waits a bounded time for a state, then compares it.
    task automatic wait_state(logic [3:0] exp);
        int k;
        k = 0;
        while (state !== exp && k < 40) begin
            cyc();
            k++;
        end
        chk("power state", {28'h0, exp}, {28'h0, state});
    endtask
    task automatic boot();
        cyc();
        boot_req = 1'b1;
        cyc();
        boot_req = 1'b0;
        wait_state(ST_RUN);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Counts shutdown request pulses and cuts a hang short.
    always @(posedge mclk) begin
        cycles++;
        if (sreq === 1'b1) n_req++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        cyc(6);
        srst = 1'b0;
        chk("power enable", 32'h0, {31'h0, pwr});
        for (int i = 0; i < 8; i++) rd8(ra[i], rv[i]);
        wr8(8'h40, 8'h5a);
        rd8(8'h40, 8'h00);
        wr8(8'h1c, 8'h03);
        wr8(8'h1d, 8'h01);
        rd8(8'h1c, 8'h03);
        rd8(8'h1d, 8'h01);
        wr8(8'h1d, 8'h00);
        wr8(8'h1c, 8'h02);
        $display("test registers done");
        wr32(8'h28, 32'hfe);
        secs(3);
        rd32(8'h28, 32'h101);
        wr32(8'h2c, 32'h200);
        chk("wake pending", 32'h0, {31'h0, wpend});
        chk("power state", {28'h0, ST_OFF}, {28'h0, state});
        wr8(8'h29, 8'h02);
        chk("wake pending", 32'h1, {31'h0, wpend});
        cyc();
        chk("power state", {28'h0, ST_BOOT}, {28'h0, state});
        rd32(8'h2c, 32'h0);
        $display("test wake done");
        wr8(8'h21, 8'h01);
        secs(9);
        chk("power state", {28'h0, ST_BOOT}, {28'h0, state});
        secs(1);
        cyc();
        chk("power enable", 32'h0, {31'h0, pwr});
        $display("test boot timeout done");
        answer = 1'b1;
        clean = 1'b1;
        boot();
        wr8(8'h1e, 8'h0a);
        wr8(8'h1f, 8'h00);
        vin = 1'b1;
        vbat = 1'b1;
        wait_state(ST_SHDN);
        vbat = 1'b0;
        cyc(3);
        chk("shutdown requests", 32'h1, n_req);
        ticks(1);
        cyc();
        chk("power enable", 32'h1, {31'h0, pwr});
        ticks(1);
        cyc();
        chk("power enable", 32'h0, {31'h0, pwr});
        $display("test battery shutdown done");
        vin = 1'b0;
        clean = 1'b0;
        boot();
        wr8(8'h1e, 8'h00);
        vin = 1'b1;
        cyc(2);
        chk("power state", {28'h0, ST_SHDN}, {28'h0, state});
        iout = 1'b1;
        cyc(3);
        ticks(2);
        cyc();
        chk("power enable", 32'h0, {31'h0, pwr});
        $display("test input loss done");
        iout = 1'b0;
        vin = 1'b0;
        wr8(8'h1e, 8'h01);
        wr8(8'h22, 8'h01);
        boot();
        vin = 1'b1;
        secs(59);
        chk("power state", {28'h0, ST_RUN}, {28'h0, state});
        secs(1);
        cyc();
        chk("power state", {28'h0, ST_SHDN}, {28'h0, state});
        secs(9);
        chk("power state", {28'h0, ST_SHDN}, {28'h0, state});
        secs(1);
        cyc();
        chk("power enable", 32'h0, {31'h0, pwr});
        wr8(8'h1c, 8'h64);
        rd8(8'h1c, 8'h64);
        $display("test timed shutdown done");
        tally_and_finish();
    end
endmodule
